// File: atf_consts.svh
// Contract
// - true ide: cs0 with a2..a0 picks task file register; cs1 with 6 picks alt/control.
// - true ide transfer width follows register: data 16 bits, all others 8 bits.
// - set features may narrow pio data to 8 bits on the low lane.
// - dmack with both chip selects negated moves a 16-bit dma word.
// - data register is a 16-bit port to the internal sector buffer.
// - odd register also answers at even address minus one on d15-d8.
// - word access at offset 1 is a word data access.
// - duplicates at 8, 9 and d accept every byte and word combination; code ignores a ce2-only byte at d.
// - low-lane byte: a0=0 even byte, a0=1 at 9 odd byte; ce2-only odd on high lane.
// - register select is 0 for i/o mode, 1 for memory mode.
// - error/feature at 1 and d low lane; high lane at 1 odd, d word.
// - error register read-only at 1 and d, reports failure cause.
// - error bit7 bad block, bit6 uncorrectable, bits 5,3,1 read zero.
// - error bit4 sector not found, bit0 general error.
// - error bit2 command aborted.
// - ce2-only write at offset 0 loads feature from d15-d8.
// - offset 3 holds start sector or block address 7..0.
// - offset 4 holds cylinder low or block address 15..8.
// - offset 5 holds cylinder high or block address 23..16.
// - offset 6 selects drive, head and addressing mode.
// - drive/head bit6 block mode, bits3..0 head, bits 7 and 5 read one.
// - drive/head bit4 drive number; respond only when it matches own; code checks it in true ide only, never for dma or drive/head accesses.
`ifndef ATF_CONSTS_SVH
`define ATF_CONSTS_SVH
`define ATF_OFS_DATA       4'h0
`define ATF_OFS_ERROR      4'h1
`define ATF_OFS_COUNT      4'h2
`define ATF_OFS_SECTOR     4'h3
`define ATF_OFS_CYL_LOW    4'h4
`define ATF_OFS_CYL_HIGH   4'h5
`define ATF_OFS_DRIVE_HEAD 4'h6
`define ATF_OFS_STATUS     4'h7
`define ATF_OFS_DUP_EVEN   4'h8
`define ATF_OFS_DUP_ODD    4'h9
`define ATF_OFS_DUP_ERROR  4'hD
`define ATF_OFS_ALT        4'hE
`define ATF_IDE_ALT_ADDR   3'h6
`define ATF_DH_LBA_BIT     6
`define ATF_DH_DRV_BIT     4
`define ATF_DH_FIXED_MASK  8'hA0
`define ATF_ERR_BBK_BIT    7
`define ATF_ERR_UNC_BIT    6
`define ATF_ERR_SECTOR_NOT_FOUND_FLAG_BIT   4
`define ATF_ERR_COMMAND_ABORTED_FLAG_BIT   2
`define ATF_ERR_GEN_BIT    0
`define ATF_ERR_ZERO_MASK  8'h2A
`define ATF_RST_BYTE       8'h00
`define ATF_RST_DH         8'hA0
`endif

// File: atf_host_model.sv
// Purpose: host controller model driving selects, strobes and bus
// Assumes: card syncs its pins, so setup and strobe widths are generous
// Notes:   released bus shows the inverted last value, there is no pull-up
module atf_host_model (
	input wire logic        core_clk,
	output logic            ce1_n,
	output logic            ce2_n,
	output logic            reg_n,
	output logic            dmack_n,
	output logic            iois16_n,
	output logic [3:0]      addr,
	output logic            rd_n,
	output logic            wr_n,
	output logic [15:0]     data_in,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{ce1_n, ce2_n, dmack_n, rd_n, wr_n, reg_n, iois16_n} = 7'h7C;
		addr = 4'h0;
		data_in = 16'hA5A5;
	end
	task automatic cycle(input logic wr, input logic [1:0] ce, input logic dma,
		input logic [3:0] a, input logic [15:0] wd, output logic [15:0] rd,
		output logic [15:0] oe);
		@(posedge core_clk);
		#1;
		{ce2_n, ce1_n, dmack_n, addr} = {ce, !dma, a};
		data_in = wr ? wd : ~data_in;
		repeat (3) @(posedge core_clk);
		#1;
		{wr_n, rd_n} = {!wr, wr};
		repeat (6) @(posedge core_clk);
		#1;
		rd = data_out;
		oe = data_oe;
		{wr_n, rd_n} = 2'b11;
		repeat (4) @(posedge core_clk);
		#1;
		{ce2_n, ce1_n, dmack_n} = 3'h7;
		data_in = ~data_in;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
endmodule

// File: atf_pkg.sv
package atf_pkg;
	typedef enum logic [2:0] {
		ATF_IDLE   = 3'b001,
		ATF_ACTIVE = 3'b010,
		ATF_DONE   = 3'b100
	} atf_cyc_type;
	typedef enum logic [1:0] {
		ATF_SEL_NONE = 2'h0,
		ATF_SEL_WORD = 2'h1,
		ATF_SEL_LOW  = 2'h2,
		ATF_SEL_HIGH = 2'h3
	} atf_lane_type;
endpackage

// File: atf_sync.sv
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: inputs asynchronous to core_clk
// Notes:   first stage read only by second stage
module atf_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync
);
	logic [W-1:0] meta_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q   <= '0;
			pin_sync <= '0;
		end else begin
			meta_q   <= pin_in;
			pin_sync <= meta_q;
		end
	end
endmodule

// File: atf_task_file.sv
// Purpose: task file decode, lanes and address registers of the card
// Assumes: strobes and selects are pins, synchronised here; one access per strobe
// Notes:   sector count, status and command live outside this block
`include "atf_consts.svh"
module atf_task_file
	import atf_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        true_ide_mode,
	input  wire logic        ce1_n,
	input  wire logic        ce2_n,
	input  wire logic        reg_n,
	input  wire logic        dmack_n,
	input  wire logic [3:0]  addr,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        iois16_n,
	input  wire logic [15:0] data_in,
	output logic      [15:0] data_out,
	output logic      [15:0] data_oe,
	input  wire logic        own_drive,
	input  wire logic        byte_mode_en,
	input  wire logic [15:0] buf_rd_word,
	output logic             buf_rd_pop,
	output logic      [15:0] buf_wr_word,
	output logic             buf_wr_push,
	output logic             buf_is_dma,
	input  wire logic [4:0]  err_set,
	input  wire logic        err_clear,
	input  wire logic        addr_upd,
	input  wire logic [27:0] addr_upd_val,
	output logic      [7:0]  feature_q,
	output logic             feature_wr,
	output logic      [7:0]  start_sector_q,
	output logic      [7:0]  start_cylinder_low_q,
	output logic      [7:0]  start_cylinder_high_q,
	output logic      [7:0]  drive_head_select_q,
	output logic             drive_match
);
	logic [7:0]  ctl_s;
	logic [3:0]  addr_s;
	logic [15:0] din_s;
	logic [7:0]  error_cause_q;
	logic [7:0]  odd_hold_q;
	logic        odd_pend_q;
	logic        rd_d1_q;
	logic        wr_d1_q;
	atf_cyc_type cyc_q;
	atf_cyc_type cyc_d;

	atf_sync #(.W(8)) u_sync_ctl (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pin_in   ({ce1_n, ce2_n, reg_n, dmack_n, rd_n, wr_n, iois16_n, true_ide_mode}),
		.pin_sync (ctl_s)
	);
	atf_sync #(.W(20)) u_sync_dat (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pin_in   ({addr, data_in}),
		.pin_sync ({addr_s, din_s})
	);

	wire s_ce1    = ~ctl_s[7];
	wire s_ce2    = ~ctl_s[6];
	wire s_reg    = ~ctl_s[5];
	wire s_dmack  = ~ctl_s[4];
	wire s_rd     = ~ctl_s[3];
	wire s_wr     = ~ctl_s[2];
	wire s_io16   = ~ctl_s[1];
	wire s_ide    = ctl_s[0];
	wire rd_start = s_rd & ~rd_d1_q;
	wire wr_start = s_wr & ~wr_d1_q;

	// byte offset into the task file; ide uses a2..a0 under cs0
	function automatic logic [3:0] ofs_of(input logic ide, input logic [3:0] a);
		ofs_of = ide ? {1'b0, a[2:0]} : a;
	endfunction

	wire        any_sel = s_ce1 | s_ce2 | s_dmack;
	wire        dma_acc = s_dmack & ~s_ce1 & ~s_ce2;
	// reg low is i/o space; memory space with reg high is task file too
	wire        tf_sel  = ~dma_acc & (s_ce1 | s_ce2);
	wire [3:0]  ofs     = ofs_of(s_ide, addr_s);
	// second chip select only reaches alternate status at 6
	wire        alt_sel = s_ide & s_ce2 & ~s_ce1 & (addr_s[2:0] == `ATF_IDE_ALT_ADDR);
	wire        pin_cs0 = s_ide ? s_ce1 : 1'b1;
	// odd byte alias at even address on d15-d8, 8-bit i/o included
	wire        hi_only = ~s_ide & s_ce2 & ~s_ce1 & ~(~s_reg & ~s_io16 & 1'b0);
	wire        word_cy = s_ide ? 1'b1 : (s_ce1 & s_ce2);
	wire [3:0]  eff_ofs = (hi_only & ~ofs[0]) ? (ofs | 4'h1) : ofs;
	// word at 0, 1, 8, 9 is data; word at d is error/feature high lane
	wire        data_word = (tf_sel & word_cy & ~s_ide & (ofs == `ATF_OFS_DATA ||
	                         ofs == `ATF_OFS_ERROR || ofs == `ATF_OFS_DUP_EVEN ||
	                         ofs == `ATF_OFS_DUP_ODD)) | dma_acc;
	// ide data port 16 bits unless byte mode set by set features
	wire        ide_data  = tf_sel & pin_cs0 & s_ide & (ofs == `ATF_OFS_DATA);
	wire        ide_word  = ide_data & ~byte_mode_en;
	wire        ide_byte  = ide_data & byte_mode_en;
	// low-lane even byte at 0/8 with a0=0, odd at 9
	wire        even_byte = tf_sel & ~word_cy & ~hi_only & ~s_ide &
	                        (ofs == `ATF_OFS_DATA || ofs == `ATF_OFS_DUP_EVEN);
	wire        odd_lo    = tf_sel & ~word_cy & ~hi_only & ~s_ide & (ofs == `ATF_OFS_DUP_ODD);
	wire        odd_hi    = tf_sel & hi_only & ((ofs == `ATF_OFS_DUP_EVEN) ||
	                        (ofs == `ATF_OFS_DUP_ODD));
	wire        err_lo    = tf_sel & ~word_cy & ~hi_only & (eff_ofs == `ATF_OFS_ERROR ||
	                        eff_ofs == `ATF_OFS_DUP_ERROR);
	wire        err_hi    = tf_sel & ((hi_only & (ofs == `ATF_OFS_DATA ||
	                        ofs == `ATF_OFS_ERROR)) | (word_cy & ~s_ide &
	                        ofs == `ATF_OFS_DUP_ERROR));
	wire        err_ide   = tf_sel & pin_cs0 & s_ide & (ofs == `ATF_OFS_ERROR);
	wire        err_any_lo = err_lo | err_ide;
	wire        reg8_sel  = tf_sel & (s_ide ? pin_cs0 : ~word_cy);
	wire [7:0]  reg8_lane = hi_only ? din_s[15:8] : din_s[7:0];
	wire        w_sector  = reg8_sel & eff_ofs == `ATF_OFS_SECTOR;
	wire        w_cyl_lo  = reg8_sel & eff_ofs == `ATF_OFS_CYL_LOW;
	wire        w_cyl_hi  = reg8_sel & eff_ofs == `ATF_OFS_CYL_HIGH;
	wire        w_dh      = reg8_sel & eff_ofs == `ATF_OFS_DRIVE_HEAD;
	wire        word_any  = data_word | ide_word;
	wire        byte_data = even_byte | odd_lo | odd_hi | ide_byte;
	wire        dev_on    = any_sel & (dma_acc | ~s_ide | drive_match | w_dh);
	wire        rd_go     = rd_start & dev_on & ~alt_sel;
	wire        wr_go     = wr_start & dev_on & ~alt_sel;

	wire [7:0]  err_view  = error_cause_q & ~`ATF_ERR_ZERO_MASK;
	wire [7:0]  dh_view   = drive_head_select_q | `ATF_DH_FIXED_MASK;
	wire [7:0]  reg8_view = (eff_ofs == `ATF_OFS_SECTOR)     ? start_sector_q :
	                        (eff_ofs == `ATF_OFS_CYL_LOW)    ? start_cylinder_low_q :
	                        (eff_ofs == `ATF_OFS_CYL_HIGH)   ? start_cylinder_high_q :
	                        (eff_ofs == `ATF_OFS_DRIVE_HEAD) ? dh_view : 8'h00;
	wire [7:0]  lo_byte   = odd_pend_q ? odd_hold_q : buf_rd_word[7:0];
	wire [15:0] rd_val    = word_any  ? buf_rd_word :
	                        even_byte | ide_byte ? {8'h00, lo_byte} :
	                        odd_lo    ? {8'h00, buf_rd_word[15:8]} :
	                        odd_hi    ? {buf_rd_word[15:8], 8'h00} :
	                        err_hi    ? {err_view, 8'h00} :
	                        err_any_lo ? {8'h00, err_view} :
	                        hi_only   ? {reg8_view, 8'h00} : {8'h00, reg8_view};
	wire [15:0] rd_oe     = word_any ? 16'hFFFF :
	                        (odd_hi | err_hi | (hi_only & ~byte_data)) ? 16'hFF00 : 16'h00FF;
	wire        reg_known = byte_data | word_any | err_hi | err_any_lo | w_sector |
	                        w_cyl_lo | w_cyl_hi | w_dh;

	always_comb begin
		cyc_d = cyc_q;
		case (cyc_q)
			ATF_IDLE: begin
				if (rd_go & reg_known)
					cyc_d = ATF_ACTIVE;
			end
			ATF_ACTIVE: begin
				if (~s_rd | ~any_sel)
					cyc_d = ATF_DONE;
			end
			ATF_DONE: cyc_d = ATF_IDLE;
			default:  cyc_d = ATF_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_q    <= ATF_IDLE;
			// synced active-low pins read as asserted in reset; asserted history blocks a false start
			rd_d1_q  <= 1'b1;
			wr_d1_q  <= 1'b1;
			data_out <= 16'h0000;
			data_oe  <= 16'h0000;
		end else begin
			cyc_q   <= cyc_d;
			rd_d1_q <= s_rd;
			wr_d1_q <= s_wr;
			// bus released when idle or deselected
			if (rd_go & reg_known) begin
				data_out <= rd_val;
				data_oe  <= rd_oe;
			end else if (cyc_d != ATF_ACTIVE) begin
				data_oe  <= 16'h0000;
			end
		end
	end

	// buffer moves; odd byte of a read pair and even byte of a write pair are held
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_rd_pop  <= 1'b0;
			buf_wr_push <= 1'b0;
			buf_wr_word <= 16'h0000;
			buf_is_dma  <= 1'b0;
			odd_hold_q  <= `ATF_RST_BYTE;
			odd_pend_q  <= 1'b0;
		end else begin
			// word leaves the buffer once its second byte has gone out
			buf_rd_pop  <= rd_go & (word_any | ((odd_lo | odd_hi) & odd_pend_q) |
			               ((even_byte | ide_byte) & odd_pend_q));
			buf_wr_push <= wr_go & (word_any | ((even_byte | ide_byte) & odd_pend_q) |
			               odd_lo | odd_hi);
			buf_is_dma  <= dma_acc;
			if (wr_go & word_any) begin
				buf_wr_word <= din_s;
			end else if (wr_go & (odd_lo | odd_hi)) begin
				buf_wr_word <= {odd_hi ? din_s[15:8] : din_s[7:0], odd_hold_q};
				odd_pend_q  <= 1'b0;
			end else if (wr_go & (even_byte | ide_byte)) begin
				if (odd_pend_q)
					buf_wr_word <= {din_s[7:0], odd_hold_q};
				else
					odd_hold_q <= din_s[7:0];
				odd_pend_q <= ~odd_pend_q;
			end else if (rd_go & (even_byte | ide_byte)) begin
				odd_hold_q <= odd_pend_q ? odd_hold_q : buf_rd_word[15:8];
				odd_pend_q <= ~odd_pend_q;
			end else if (rd_go & (odd_lo | odd_hi)) begin
				odd_pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			feature_q             <= `ATF_RST_BYTE;
			feature_wr            <= 1'b0;
			start_sector_q        <= `ATF_RST_BYTE;
			start_cylinder_low_q  <= `ATF_RST_BYTE;
			start_cylinder_high_q <= `ATF_RST_BYTE;
			drive_head_select_q   <= `ATF_RST_DH;
		end else begin
			feature_wr <= wr_go & (err_hi | err_any_lo);
			if (wr_go & err_hi)
				feature_q <= din_s[15:8];
			else if (wr_go & err_any_lo)
				feature_q <= din_s[7:0];
			if (addr_upd) begin
				start_sector_q        <= addr_upd_val[7:0];
				start_cylinder_low_q  <= addr_upd_val[15:8];
				start_cylinder_high_q <= addr_upd_val[23:16];
				drive_head_select_q   <= {drive_head_select_q[7:4], addr_upd_val[27:24]};
			end else if (wr_go) begin
				if (w_sector)
					start_sector_q <= reg8_lane;
				if (w_cyl_lo)
					start_cylinder_low_q <= reg8_lane;
				if (w_cyl_hi)
					start_cylinder_high_q <= reg8_lane;
				// bits 7 and 5 forced so reads always show one
				if (w_dh)
					drive_head_select_q <= reg8_lane | `ATF_DH_FIXED_MASK;
			end
		end
	end

	// error causes; set beats clear in the same cycle
	wire [7:0] err_in = {err_set[4], err_set[3], 1'b0, err_set[2], 1'b0,
	                     err_set[1], 1'b0, err_set[0]};
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			error_cause_q <= `ATF_RST_BYTE;
			drive_match   <= 1'b0;
		end else begin
			error_cause_q <= (err_clear ? 8'h00 : error_cause_q) | err_in;
			drive_match   <= drive_head_select_q[`ATF_DH_DRV_BIT] == own_drive;
		end
	end
endmodule

// File: atf_task_file_asserts.sv
// Purpose: port-level checks of the task file block
// Assumes: one clock domain, async active-low reset
// Notes:   pin sync puts every answer three to six cycles behind its strobe
module atf_task_file_asserts (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        true_ide_mode,
	input wire logic        ce1_n,
	input wire logic        ce2_n,
	input wire logic        dmack_n,
	input wire logic [3:0]  addr,
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic        byte_mode_en,
	input wire logic        own_drive,
	input wire logic        addr_upd,
	input wire logic [15:0] data_oe,
	input wire logic        buf_rd_pop,
	input wire logic        buf_wr_push,
	input wire logic        feature_wr,
	input wire logic [7:0]  start_sector_q,
	input wire logic [7:0]  drive_head_select_q,
	input wire logic        drive_match
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_ide_rd;
		$fell(rd_n) && true_ide_mode && !ce1_n && ce2_n && dmack_n && addr[2:0] == 3'h0
			&& drive_match;
	endsequence
	sequence s_dma_rd;
		$fell(rd_n) && !dmack_n && ce1_n && ce2_n;
	endsequence
	property p_no_sel_quiet; (ce1_n && ce2_n && dmack_n)[*6] |-> data_oe == 16'h0000; endproperty
	property p_no_sel_hold;
		(ce1_n && ce2_n && dmack_n && !addr_upd)[*6] |=> $stable(start_sector_q);
	endproperty
	property p_dh_fixed; (drive_head_select_q & 8'hA0) == 8'hA0; endproperty
	property p_drive_match;
		($stable(drive_head_select_q) && $stable(own_drive))[*2]
			|-> drive_match == (drive_head_select_q[4] == own_drive);
	endproperty
	property p_feature_pulse; feature_wr |-> !$past(wr_n, 3) ##1 !feature_wr; endproperty
	property p_pop_rd; buf_rd_pop |-> !$past(rd_n, 3); endproperty
	property p_push_wr; buf_wr_push |-> !$past(wr_n, 3); endproperty
	property p_ide_word; s_ide_rd ##0 !byte_mode_en |-> ##[3:6] data_oe == 16'hFFFF; endproperty
	property p_ide_byte; s_ide_rd ##0 byte_mode_en |-> ##[3:6] data_oe == 16'h00FF; endproperty
	property p_dma_word; s_dma_rd |-> ##[3:6] buf_rd_pop ##[0:2] data_oe == 16'hFFFF; endproperty
	property p_oe_release; $rose(rd_n) |-> ##[1:6] data_oe == 16'h0000; endproperty
	a_no_sel_quiet: assert property (p_no_sel_quiet) else $error("bus driven unselected");
	a_no_sel_hold: assert property (p_no_sel_hold) else $error("register moved");
	a_dh_fixed: assert property (p_dh_fixed) else $error("drive head fixed bits low");
	a_drive_match: assert property (p_drive_match) else $error("drive match wrong");
	a_feature_pulse: assert property (p_feature_pulse) else $error("feature pulse bad");
	a_pop_rd: assert property (p_pop_rd) else $error("pop without read");
	a_push_wr: assert property (p_push_wr) else $error("push without write");
	a_ide_word: assert property (p_ide_word) else $error("ide data not word wide");
	a_ide_byte: assert property (p_ide_byte) else $error("ide byte mode not low lane");
	a_dma_word: assert property (p_dma_word) else $error("dma word missing");
	a_oe_release: assert property (p_oe_release) else $error("bus not released");
endmodule

bind atf_task_file atf_task_file_asserts chk_u (.core_clk(core_clk), .rst_n(rst_n),
	.true_ide_mode(true_ide_mode), .ce1_n(ce1_n), .ce2_n(ce2_n), .dmack_n(dmack_n),
	.addr(addr), .rd_n(rd_n), .wr_n(wr_n), .byte_mode_en(byte_mode_en), .own_drive(own_drive),
	.addr_upd(addr_upd), .data_oe(data_oe), .buf_rd_pop(buf_rd_pop), .buf_wr_push(buf_wr_push),
	.feature_wr(feature_wr), .start_sector_q(start_sector_q),
	.drive_head_select_q(drive_head_select_q), .drive_match(drive_match));

// File: test_ata_task_file_decode.sv
// Purpose: self-checking bench for the task file block
// Assumes: host model sequences every pin cycle
// Notes:   expectations come from the register map, never from outputs
module test_ata_task_file_decode;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk, rst_n, true_ide_mode, own_drive, byte_mode_en, err_clear, addr_upd;
	logic        ce1_n, ce2_n, reg_n, dmack_n, iois16_n, rd_n, wr_n, buf_is_dma, drive_match;
	logic        buf_rd_pop, buf_wr_push, feature_wr, last_pop_dma;
	logic [3:0]  addr;
	logic [4:0]  err_set;
	logic [7:0]  feature_q, sect_q, cyl_lo_q, cyl_hi_q, dh_q;
	logic [15:0] data_in, data_out, data_oe, buf_rd_word, buf_wr_word, last_push, rd, oe;
	logic [27:0] addr_upd_val;
	int          n_fail = 0, num_checks = 0, n_pop = 0, cyc = 0;
	int          err_pos[5] = '{0, 2, 4, 6, 7};
	atf_task_file dut_u (.core_clk(core_clk), .rst_n(rst_n), .true_ide_mode(true_ide_mode),
		.ce1_n(ce1_n), .ce2_n(ce2_n), .reg_n(reg_n), .dmack_n(dmack_n), .addr(addr),
		.rd_n(rd_n), .wr_n(wr_n), .iois16_n(iois16_n), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .own_drive(own_drive), .byte_mode_en(byte_mode_en),
		.buf_rd_word(buf_rd_word), .buf_rd_pop(buf_rd_pop), .buf_wr_word(buf_wr_word),
		.buf_wr_push(buf_wr_push), .buf_is_dma(buf_is_dma), .err_set(err_set),
		.err_clear(err_clear), .addr_upd(addr_upd), .addr_upd_val(addr_upd_val),
		.feature_q(feature_q), .feature_wr(feature_wr), .start_sector_q(sect_q),
		.start_cylinder_low_q(cyl_lo_q), .start_cylinder_high_q(cyl_hi_q),
		.drive_head_select_q(dh_q), .drive_match(drive_match));
	atf_host_model host_u (.core_clk(core_clk), .ce1_n(ce1_n), .ce2_n(ce2_n), .reg_n(reg_n),
		.dmack_n(dmack_n), .iois16_n(iois16_n), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ceiling well above the ~520 cycles the sequence needs
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (buf_rd_pop) begin
			n_pop        <= n_pop + 1;
			last_pop_dma <= buf_is_dma;
		end
		if (buf_wr_push)
			last_push <= buf_wr_word;
		if (cyc == 5000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic reg_write(input logic [1:0] ce, input logic [3:0] a, input logic [15:0] d);
		host_u.cycle(1'b1, ce, 1'b0, a, d, rd, oe);
	endtask
	task automatic reg_read(input logic [1:0] ce, input logic [3:0] a);
		host_u.cycle(1'b0, ce, 1'b0, a, 16'h0000, rd, oe);
	endtask
	task automatic pulse(input logic [4:0] es, input logic ec, input logic au);
		@(posedge core_clk);
		#1;
		{err_set, err_clear, addr_upd} = {es, ec, au};
		@(posedge core_clk);
		#1;
		{err_set, err_clear, addr_upd} = 7'h00;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		{rst_n, own_drive, byte_mode_en, true_ide_mode} = 4'b0101;
		{err_set, err_clear, addr_upd} = 7'h00;
		addr_upd_val = 28'h9876543;
		buf_rd_word = 16'hC3A5;
		repeat (5) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		check("reset regs", {8'h00, sect_q, dh_q, 8'h00}, 32'h0000A000);
		reg_write(2'b10, 4'h6, 16'h0015);
		check("drive head", {dh_q, 23'h000000, drive_match}, 32'hB5000001);
		for (int i = 3; i < 6; i++) begin
			reg_write(2'b10, 4'(i), 16'h0030 + 16'(i));
			reg_read(2'b10, 4'(i));
			check("readback", {oe, rd & oe}, {16'h00FF, 16'h0030 + 16'(i)});
		end
		check("addr regs", {8'h00, sect_q, cyl_lo_q, cyl_hi_q}, 32'h00333435);
		pulse(5'h00, 1'b0, 1'b1);
		check("completion", {sect_q, cyl_lo_q, cyl_hi_q, dh_q}, 32'h436587B9);
		for (int b = 0; b < 5; b++) begin
			pulse(5'h00, 1'b1, 1'b0);
			pulse(5'(1 << b), 1'b0, 1'b0);
			reg_read(2'b10, 4'h1);
			check("error", {oe, rd & oe}, {16'h00FF, 16'h0001 << err_pos[b]});
		end
		reg_write(2'b10, 4'h1, 16'h0003);
		reg_read(2'b10, 4'h1);
		check("feature", {16'h0000, feature_q, rd[7:0]}, 32'h00000380);
		reg_read(2'b10, 4'h0);
		check("pio word", {oe, rd}, 32'hFFFFC3A5);
		check("pops", 32'(n_pop), 32'h00000001);
		byte_mode_en = 1'b1;
		reg_read(2'b10, 4'h0);
		check("byte even", {oe, rd & oe}, 32'h00FF00A5);
		reg_read(2'b10, 4'h0);
		check("byte odd", {oe, rd & oe}, 32'h00FF00C3);
		byte_mode_en = 1'b0;
		reg_write(2'b10, 4'h0, 16'h1234);
		check("push", {16'h0000, last_push}, 32'h00001234);
		host_u.cycle(1'b0, 2'b11, 1'b1, 4'h7, 16'h0000, rd, oe);
		check("dma", {oe, rd}, 32'hFFFFC3A5);
		check("dma flag", 32'(last_pop_dma), 32'h00000001);
		reg_write(2'b01, 4'h6, 16'h0000);
		check("alt ignored", {24'h000000, dh_q}, 32'h000000B9);
		true_ide_mode = 1'b0;
		reg_read(2'b10, 4'h8);
		check("even at 8", {oe, rd & oe}, 32'h00FF00A5);
		reg_read(2'b10, 4'h9);
		check("odd at 9", {oe, rd & oe}, 32'h00FF00C3);
		check("pair pops", 32'(n_pop), 32'h00000004);
		reg_read(2'b00, 4'h1);
		check("word at 1", {oe, rd}, 32'hFFFFC3A5);
		check("word flag", 32'(last_pop_dma), 32'h00000000);
		reg_read(2'b00, 4'hD);
		check("error at d", {16'h0000, oe[15:8], rd[15:8]}, 32'h0000FF80);
		reg_write(2'b01, 4'h0, 16'h5A00);
		check("feature high", {24'h000000, feature_q}, 32'h0000005A);
		reg_write(2'b11, 4'h3, 16'hFFFF);
		reg_read(2'b11, 4'h3);
		check("no select", {oe, 8'h00, sect_q}, 32'h00000043);
		tally_and_finish();
	end
endmodule
